// ### shared/cold_load_pkg.sv
// Purpose: constants for the cold load pickup block
// Assumes: 100 MHz hclk, AHB-Lite register access
// Notes: register offsets are byte addresses
package cold_load_pkg;
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] uc_thr_addr = 8'h04;
  localparam logic [7:0] inr_thr_addr = 8'h08;
  localparam logic [7:0] t_off_addr = 8'h0c;
  localparam logic [7:0] t_settle_addr = 8'h10;
  localparam logic [7:0] t_max_addr = 8'h14;
  localparam logic [7:0] status_addr = 8'h18;
  localparam logic [7:0] irq_stat_addr = 8'h1c;
  localparam logic [7:0] irq_mask_addr = 8'h20;
  localparam int cur_w = 16;
  localparam int tmr_w = 32;
  localparam int irq_w = 3;
  // ctrl fields
  localparam int mode_lsb = 0;
  localparam int enable_bit = 2;
  localparam int ext_sel_bit = 3;
  localparam int int_sel_bit = 4;
  // status fields
  localparam int st_active_bit = 0;
  localparam int st_uc_bit = 1;
  localparam int st_inrush_bit = 2;
  localparam int st_blocked_bit = 3;
  // interrupt fields
  localparam int ev_rise_bit = 0;
  localparam int ev_fall_bit = 1;
  localparam int ev_inrush_bit = 2;
  localparam logic [31:0] ctrl_rst = 32'h0000_0004;
  localparam logic [cur_w-1:0] uc_thr_rst = 16'h0100;
  localparam logic [cur_w-1:0] inr_thr_rst = 16'h1000;
  localparam logic [tmr_w-1:0] t_off_rst = 32'h0000_03e8;
  localparam logic [tmr_w-1:0] t_settle_rst = 32'h0000_0064;
  localparam logic [tmr_w-1:0] t_max_rst = 32'h0000_07d0;
  // 90% drop-out as 9/10
  localparam int drop_num = 9;
  localparam int drop_den = 10;
  typedef enum logic [1:0] {mode_bkr, mode_uc, mode_and, mode_or} det_mode_t;
  typedef enum logic [1:0] {st_warm, st_load_off, st_cold, st_supervise} pickup_state_t;
endpackage

// ### design/tick_timer.sv
// Purpose: preset loaded down counter
// Assumes: load wins over run
// Notes: done is a level while count sits at zero after a run
`timescale 1ns/10ps
module tick_timer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic load,
  input wire logic run,
  input wire logic [cold_load_pkg::tmr_w-1:0] preset,
  // status
  output logic done
);
  logic [cold_load_pkg::tmr_w-1:0] cnt_ff;
  logic armed_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_ff <= '0;
      armed_ff <= 1'b0;
    end
    else if (load)
    begin
      cnt_ff <= preset;
      armed_ff <= 1'b1;
    end
    else if (!run)
      armed_ff <= 1'b0;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - 1'b1;
  end

  assign done = armed_ff && run && (cnt_ff == '0);
endmodule

// ### design/cold_load_pickup.sv
// Purpose: cold load pickup with AHB-Lite registers
// Assumes: current samples and threshold share one scale; status pins come from other clock domains
// Notes: zero-wait slave, output flag only
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module cold_load_pickup (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // plant inputs
  input wire logic breaker_position,
  input wire logic [cold_load_pkg::cur_w-1:0] load_current,
  input wire logic ext_block,
  input wire logic int_block,
  input wire logic autoreclose_running,
  // indications
  output logic cold_load_active,
  output logic cold_load_undercurrent_flag,
  output logic irq
);
  logic [31:0] ctrl_ff;
  logic [cold_load_pkg::cur_w-1:0] uc_thr_ff, inr_thr_ff;
  logic [cold_load_pkg::tmr_w-1:0] t_off_ff, t_settle_ff, t_max_ff, low_run_ff;
  logic [cold_load_pkg::irq_w-1:0] irq_stat_ff, irq_mask_ff, ev;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [1:0] bkr_s_ff, ext_s_ff, int_s_ff, reclose_s_ff;
  logic [cold_load_pkg::cur_w-1:0] cur_ff;
  cold_load_pkg::pickup_state_t state_ff, nxt_state;
  logic active_ff, inrush_ff, uc_ff, blocked_ff;
  logic bkr_open, under, cold_cond, blocked, below_drop, above_thr;
  logic off_done, settle_done, max_done, start_sup, settle_run;
  logic [cold_load_pkg::cur_w+3:0] cur_x10, thr_x9;

  // bus write capture; zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= hsel && hready && htrans[1] && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr_pend_ff && (wr_addr_ff == a);
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff <= cold_load_pkg::ctrl_rst;
      uc_thr_ff <= cold_load_pkg::uc_thr_rst;
      inr_thr_ff <= cold_load_pkg::inr_thr_rst;
      t_off_ff <= cold_load_pkg::t_off_rst;
      t_settle_ff <= cold_load_pkg::t_settle_rst;
      t_max_ff <= cold_load_pkg::t_max_rst;
      irq_mask_ff <= '0;
    end
    else
    begin
      if (wr_hit(cold_load_pkg::ctrl_addr))
        ctrl_ff <= {27'h0, hwdata[4:0]};
      if (wr_hit(cold_load_pkg::uc_thr_addr))
        uc_thr_ff <= hwdata[cold_load_pkg::cur_w-1:0];
      if (wr_hit(cold_load_pkg::inr_thr_addr))
        inr_thr_ff <= hwdata[cold_load_pkg::cur_w-1:0];
      if (wr_hit(cold_load_pkg::t_off_addr))
        t_off_ff <= hwdata;
      if (wr_hit(cold_load_pkg::t_settle_addr))
        t_settle_ff <= hwdata;
      if (wr_hit(cold_load_pkg::t_max_addr))
        t_max_ff <= hwdata;
      if (wr_hit(cold_load_pkg::irq_mask_addr))
        irq_mask_ff <= hwdata[cold_load_pkg::irq_w-1:0];
    end
  end

  // read data registered in the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr)
        cold_load_pkg::ctrl_addr: hrdata <= ctrl_ff;
        cold_load_pkg::uc_thr_addr: hrdata <= {16'h0, uc_thr_ff};
        cold_load_pkg::inr_thr_addr: hrdata <= {16'h0, inr_thr_ff};
        cold_load_pkg::t_off_addr: hrdata <= t_off_ff;
        cold_load_pkg::t_settle_addr: hrdata <= t_settle_ff;
        cold_load_pkg::t_max_addr: hrdata <= t_max_ff;
        cold_load_pkg::status_addr: hrdata <= {28'h0, blocked_ff, inrush_ff, uc_ff, active_ff};
        cold_load_pkg::irq_stat_addr: hrdata <= {29'h0, irq_stat_ff};
        cold_load_pkg::irq_mask_addr: hrdata <= {29'h0, irq_mask_ff};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {hreadyout, hresp} <= 2'b10;
    else
      {hreadyout, hresp} <= 2'b10;
  end

  // two-stage synchronisers for pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bkr_s_ff <= 2'b00;
      ext_s_ff <= 2'b00;
      int_s_ff <= 2'b00;
      reclose_s_ff <= 2'b00;
    end
    else
    begin
      bkr_s_ff <= {bkr_s_ff[0], breaker_position};
      ext_s_ff <= {ext_s_ff[0], ext_block};
      int_s_ff <= {int_s_ff[0], int_block};
      reclose_s_ff <= {reclose_s_ff[0], autoreclose_running};
    end
  end

  // current sample from same-domain measurement logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cur_ff <= '0;
    else
      cur_ff <= load_current;
  end

  // breaker_position high means closed
  assign bkr_open = !bkr_s_ff[1];
  assign under = cur_ff < uc_thr_ff;
  always_comb
  begin
    case (cold_load_pkg::det_mode_t'(ctrl_ff[cold_load_pkg::mode_lsb +: 2]))
      cold_load_pkg::mode_bkr: cold_cond = bkr_open;
      cold_load_pkg::mode_uc: cold_cond = under;
      cold_load_pkg::mode_and: cold_cond = bkr_open && under;
      cold_load_pkg::mode_or: cold_cond = bkr_open || under;
      default: cold_cond = 1'b0;
    endcase
  end

  assign blocked = !ctrl_ff[cold_load_pkg::enable_bit]
    || (ctrl_ff[cold_load_pkg::ext_sel_bit] && ext_s_ff[1])
    || (ctrl_ff[cold_load_pkg::int_sel_bit] && int_s_ff[1])
    || reclose_s_ff[1];

  // compare against 90% without a divider: 10*i vs 9*thr
  assign cur_x10 = 20'(cur_ff) * 20'(cold_load_pkg::drop_den);
  assign thr_x9 = 20'(inr_thr_ff) * 20'(cold_load_pkg::drop_num);
  assign below_drop = cur_x10 <= thr_x9;
  assign above_thr = cur_ff > inr_thr_ff;

  assign start_sup = (state_ff == cold_load_pkg::st_cold) && !cold_cond;
  assign settle_run = (state_ff == cold_load_pkg::st_supervise) && !inrush_ff && below_drop;
  // run length of low current, kept apart from the timer so the check below is independent
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_run_ff <= '0;
    else
      low_run_ff <= settle_run ? low_run_ff + 1'b1 : '0;
  end

  tick_timer u_off (
    .hclk(hclk),
    .hresetn(hresetn),
    .load((state_ff == cold_load_pkg::st_warm) && cold_cond && !blocked),
    .run(state_ff == cold_load_pkg::st_load_off),
    .preset(t_off_ff),
    .done(off_done)
  );

  // settle reloads whenever current climbs back above 0.9 threshold
  tick_timer u_settle (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(start_sup || ((state_ff == cold_load_pkg::st_supervise) && !settle_run)),
    .run(settle_run),
    .preset(t_settle_ff),
    .done(settle_done)
  );

  tick_timer u_max (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(start_sup),
    .run(state_ff == cold_load_pkg::st_supervise),
    .preset(t_max_ff),
    .done(max_done)
  );

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      cold_load_pkg::st_warm:
        if (cold_cond && !blocked)
          nxt_state = cold_load_pkg::st_load_off;
      cold_load_pkg::st_load_off:
        if (!cold_cond)
          nxt_state = cold_load_pkg::st_warm;
        else if (off_done)
          nxt_state = cold_load_pkg::st_cold;
      cold_load_pkg::st_cold:
        if (!cold_cond)
          nxt_state = cold_load_pkg::st_supervise;
      cold_load_pkg::st_supervise:
        if (settle_done || max_done)
          nxt_state = cold_load_pkg::st_warm;
        else if (cold_cond)
          nxt_state = cold_load_pkg::st_cold;
      default: nxt_state = cold_load_pkg::st_warm;
    endcase
    if (blocked)
      nxt_state = cold_load_pkg::st_warm;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= cold_load_pkg::st_warm;
    else
      state_ff <= nxt_state;
  end

  // inrush tracker: set above threshold, clear at 90%
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      inrush_ff <= 1'b0;
    else if (nxt_state != cold_load_pkg::st_supervise)
      inrush_ff <= 1'b0;
    else if (above_thr)
      inrush_ff <= 1'b1;
    else if (below_drop)
      inrush_ff <= 1'b0;
  end

  // indication only; there is no trip path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      active_ff <= 1'b0;
      uc_ff <= 1'b0;
      blocked_ff <= 1'b0;
    end
    else
    begin
      active_ff <= (nxt_state == cold_load_pkg::st_cold) || (nxt_state == cold_load_pkg::st_supervise);
      uc_ff <= under && !blocked;
      blocked_ff <= blocked;
    end
  end

  assign ev = {(nxt_state == cold_load_pkg::st_supervise) && above_thr && !inrush_ff,
    active_ff && !((nxt_state == cold_load_pkg::st_cold) || (nxt_state == cold_load_pkg::st_supervise)),
    !active_ff && (nxt_state == cold_load_pkg::st_cold)};

  // set wins over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_ff <= '0;
    else if (wr_hit(cold_load_pkg::irq_stat_addr))
      irq_stat_ff <= (irq_stat_ff & ~hwdata[cold_load_pkg::irq_w-1:0]) | ev;
    else
      irq_stat_ff <= irq_stat_ff | ev;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_ff & irq_mask_ff);
  end

  assign cold_load_active = active_ff;
  assign cold_load_undercurrent_flag = uc_ff;

  a_off_to_active_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == cold_load_pkg::st_load_off) && off_done && cold_cond && !blocked |=> active_ff)
    else $error("active not raised after load-off");
  b_block_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
    blocked |=> !active_ff && (state_ff == cold_load_pkg::st_warm))
    else $error("block did not inhibit");
  c_reclose_blocks_a: assert property (@(posedge hclk) disable iff (!hresetn)
    reclose_s_ff[1] |=> !active_ff)
    else $error("autoreclose did not block");
  d_max_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == cold_load_pkg::st_supervise) && max_done |=> !active_ff)
    else $error("max-block expiry kept active");
  e_settle_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == cold_load_pkg::st_supervise) && settle_done && !blocked |=> !active_ff)
    else $error("settle expiry kept active");
  f_inrush_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == cold_load_pkg::st_supervise) && (nxt_state == cold_load_pkg::st_supervise)
    && above_thr |=> inrush_ff)
    else $error("inrush not flagged");
  g_inrush_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    inrush_ff && below_drop && !above_thr |=> !inrush_ff)
    else $error("inrush did not end at drop-out");
  h_settle_needs_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    settle_done |-> below_drop && !inrush_ff && (low_run_ff >= t_settle_ff))
    else $error("settle done before current stayed low");
  i_cold_shows_uc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    under && !blocked |=> uc_ff)
    else $error("undercurrent flag missing");
  j_start_loads_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff == cold_load_pkg::st_warm) && cold_cond && !blocked |=> state_ff == cold_load_pkg::st_load_off)
    else $error("load-off not started");
  k_cold_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_sup && !blocked |=> state_ff == cold_load_pkg::st_supervise)
    else $error("supervisor not started");
  c_active_cv: cover property (@(posedge hclk) disable iff (!hresetn) $rose(active_ff));
  c_max_cv: cover property (@(posedge hclk) disable iff (!hresetn) max_done && inrush_ff);
  c_settle_cv: cover property (@(posedge hclk) disable iff (!hresetn) settle_done);
endmodule

// ### tb/plant_model.sv
// Purpose: breaker and current transformer seen by the cold load block
// Assumes: current sampled on the line side, so it may flow with the breaker open
// Notes: breaker contacts move op_delay+1 cycles after the command
`timescale 1ns/10ps
module plant_model #(
  parameter int op_delay = 2
) (
  // clock
  input wire logic hclk,
  // commands from the bench
  input wire logic close_cmd,
  input wire logic [cold_load_pkg::cur_w-1:0] amps_cmd,
  // plant state
  output logic breaker_position = 1'b1,
  output logic [cold_load_pkg::cur_w-1:0] load_current = 16'h0800
);
  int cnt_ff = 0;
  // slow contacts: a relay never sees the command edge itself
  always @(posedge hclk)
  begin
    if (close_cmd != breaker_position && cnt_ff < op_delay)
      cnt_ff <= cnt_ff + 1;
    else
    begin
      cnt_ff <= 0;
      breaker_position <= close_cmd;
    end
    load_current <= amps_cmd;
  end
endmodule

// ### tb/cold_load_pickup_test.sv
// Purpose: self-checking bench for cold load pickup
// Assumes: zero-wait slave; presets shortened by register writes
// Notes: plant_model supplies breaker and current
`timescale 1ns/10ps
module cold_load_pickup_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ext_block = 1'b0;
  logic int_block = 1'b0;
  logic autoreclose_running = 1'b0;
  logic close_cmd = 1'b1;
  logic [15:0] amps_cmd = 16'h0800;
  logic breaker_position;
  logic [15:0] load_current;
  logic cold_load_active;
  logic cold_load_undercurrent_flag;
  logic irq;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] q;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24};
  logic [31:0] rv [7] = '{32'h4, 32'h100, 32'h1000, 32'h3e8, 32'h64, 32'h7d0, 32'h0};
  // expected active per mode and case, index mode*2+case
  logic [7:0] mode_exp = 8'hc9;

  initial
  begin
    forever #5 hclk = ~hclk;
  end

  cold_load_pickup uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .breaker_position(breaker_position), .load_current(load_current),
    .ext_block(ext_block), .int_block(int_block), .autoreclose_running(autoreclose_running),
    .cold_load_active(cold_load_active), .cold_load_undercurrent_flag(cold_load_undercurrent_flag), .irq(irq));

  plant_model plant (.hclk(hclk), .close_cmd(close_cmd), .amps_cmd(amps_cmd),
    .breaker_position(breaker_position), .load_current(load_current));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // single word transfer; entered just after an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check("hresp okay", 32'h0, 32'(hresp));
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(name, exp, q);
  endtask

  // block first so every start is from warm
  task automatic cold(input logic [1:0] mode);
    ext_block <= 1'b1;
    int_block <= 1'b0;
    autoreclose_running <= 1'b0;
    close_cmd <= 1'b0;
    amps_cmd <= 16'h0000;
    bus(1'b1, 8'h00, {27'h0, 3'b111, mode});
    tick(5);
    ext_block <= 1'b0;
    tick(40);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    tick(20000);
    fail_count++;
    $display("CHECK FAILED run_time expected finish seen timeout");
    end_of_test();
  end

  initial
  begin
    tick(10);
    hresetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 7; i++)
      rd("reset value", ra[i], rv[i]);
    check("active after reset", 32'h0, 32'(cold_load_active));
    $display("test reset values done");
    bus(1'b1, 8'h0c, 32'd20);
    bus(1'b1, 8'h10, 32'd10);
    bus(1'b1, 8'h14, 32'd500);
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 2; c++)
      begin
        ext_block <= 1'b1;
        close_cmd <= c[0];
        amps_cmd <= c[0] ? 16'h0000 : 16'h0800;
        bus(1'b1, 8'h00, {27'h0, 3'b111, m[1:0]});
        tick(5);
        ext_block <= 1'b0;
        tick(10);
        check("active early", 32'h0, 32'(cold_load_active));
        tick(30);
        check("active by mode", 32'(mode_exp[m*2+c]), 32'(cold_load_active));
        check("undercurrent flag", 32'(c[0]), 32'(cold_load_undercurrent_flag));
      end
    $display("test modes done");
    cold(2'd0);
    check("active cold", 32'h1, 32'(cold_load_active));
    check("uc flag cold", 32'h1, 32'(cold_load_undercurrent_flag));
    bus(1'b1, 8'h1c, 32'h7);
    close_cmd <= 1'b1;
    amps_cmd <= 16'h2000;
    tick(12);
    rd("inrush status", 8'h18, 32'h5);
    amps_cmd <= 16'd3687;
    tick(40);
    check("active above drop", 32'h1, 32'(cold_load_active));
    amps_cmd <= 16'd3686;
    tick(30);
    check("active after settle", 32'h0, 32'(cold_load_active));
    rd("events supervise", 8'h1c, 32'h6);
    $display("test inrush settle done");
    bus(1'b1, 8'h14, 32'd60);
    cold(2'd0);
    close_cmd <= 1'b1;
    amps_cmd <= 16'h2000;
    tick(30);
    check("active in max block", 32'h1, 32'(cold_load_active));
    tick(60);
    check("active max expired", 32'h0, 32'(cold_load_active));
    $display("test max block done");
    for (int k = 0; k < 3; k++)
    begin
      cold(2'd0);
      {autoreclose_running, int_block, ext_block} <= 3'b001 << k;
      tick(6);
      check("active blocked", 32'h0, 32'(cold_load_active));
      rd("blocked status", 8'h18, 32'h8);
    end
    cold(2'd0);
    bus(1'b1, 8'h00, 32'h4);
    {int_block, ext_block} <= 2'b11;
    tick(6);
    check("active unselected block", 32'h1, 32'(cold_load_active));
    bus(1'b1, 8'h00, 32'h0);
    tick(3);
    check("active disabled", 32'h0, 32'(cold_load_active));
    rd("disabled status", 8'h18, 32'h8);
    {int_block, ext_block} <= 2'b00;
    $display("test blocking done");
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b1, 8'h1c, 32'h7);
    cold(2'd0);
    rd("rise event", 8'h1c, 32'h1);
    check("irq masked", 32'h0, 32'(irq));
    bus(1'b1, 8'h20, 32'h1);
    tick(3);
    check("irq raised", 32'h1, 32'(irq));
    bus(1'b1, 8'h1c, 32'h1);
    tick(3);
    check("irq cleared", 32'h0, 32'(irq));
    $display("test interrupts done");
    // second reset while cold load is active
    hresetn <= 1'b0;
    tick(3);
    check("active in reset", 32'h0, 32'(cold_load_active));
    hresetn <= 1'b1;
    tick(1);
    rd("preset after reset", 8'h0c, 32'h3e8);
    $display("test second reset done");
    end_of_test();
  end
endmodule
